// File: design/mct_map.svh
// Register offsets, field positions, control/status reset value and timing counts of the clock/time base block
`ifndef MCT_MAP_SVH
`define MCT_MAP_SVH
`define MCT_CTRL_STATUS_OFS 12'h000
`define MCT_IRQ_STATUS_OFS 12'h004
`define MCT_IRQ_MASK_OFS 12'h008
`define MCT_POWER_CTRL_OFS 12'h00c
`define MCT_CTRL_STATUS_RST 8'h00
`define MCT_BIT_CLKOUT 7
`define MCT_BIT_CPUDIV_HI 6
`define MCT_BIT_CPUDIV_LO 5
`define MCT_BIT_SLOW 4
`define MCT_BIT_TB_HI 3
`define MCT_BIT_TB_LO 2
`define MCT_BIT_IRQEN 1
`define MCT_BIT_OVF 0
`define MCT_TB_PERIOD0 18'd16000
`define MCT_TB_PERIOD1 18'd32000
`define MCT_TB_PERIOD2 18'd80000
`define MCT_TB_PERIOD3 18'd200000
`endif

// File: design/mct_pkg.sv
// Types of the clock/time base block
package mct_pkg;
  typedef enum logic [1:0] {
    MCT_RUN = 2'b00,
    MCT_WAIT = 2'b01,
    MCT_ACTIVE_HALT = 2'b10,
    MCT_HALT = 2'b11
  } mct_power_type;

  typedef struct packed {
    logic clock_out_select;
    logic [1:0] cpu_div_select;
    logic slow_mode_select;
    logic [1:0] timebase_period_select;
    logic timebase_irq_enable;
    logic timebase_overflow_flag;
  } mct_csr_type;
endpackage : mct_pkg

// File: design/mct_cpu_div.sv
// CPU clock enable divider driven from the half-oscillator enable
`timescale 1ns/1ps
`default_nettype none
module mct_cpu_div (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic osc_en,
  input wire logic slow_mode,
  input wire logic [1:0] div_sel,
  output logic cpu_en
);
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [3:0] limit;

  always_comb begin
    limit = 4'h0;
    case (div_sel)
      2'b00: limit = 4'h1;
      2'b01: limit = 4'h3;
      2'b10: limit = 4'h7;
      2'b11: limit = 4'hf;
      default: limit = 4'h1;
    endcase
    nxt_cnt = (cnt_ff >= limit) ? 4'h0 : cnt_ff + 4'h1;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 4'h0;
    end else if (!slow_mode) begin
      cnt_ff <= 4'h0;
    end else if (osc_en) begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign cpu_en = osc_en & (!slow_mode | (cnt_ff == 4'h0));

  chk_normal_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !slow_mode |-> (cpu_en == osc_en)) else $error("cpu enable not equal osc enable");
endmodule : mct_cpu_div
`default_nettype wire

// File: design/mct_clock_timebase.sv
// Main clock controller with time base, APB registers and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "mct_map.svh"
// Function
// - Clock-out bit drives half-oscillator clock on pin, else pin stays GPIO
// - Slow mode divides half-oscillator clock by 2, 4, 8 or 16
// - Prescaler acts only in slow mode; otherwise CPU clock undivided
// - Time-base field picks 16000, 32000, 80000 or 200000 cycle period
// - New time-base selection takes effect at end of current period
// - Interrupt enable bit gates the time-base interrupt request
// - Halt with interrupt enabled and auto-wakeup halt clear enters active halt, not full halt
// - Enabled time-base interrupt wakes device from active halt
// - Reset clears whole control/status register
// - Interrupt raised when flag set, enable set and CPU mask clear
// - Wait mode keeps time base running; its interrupt ends wait
// - Active halt keeps counter running, control/status writes blocked (mask register still writable)
// - Full and auto-wakeup halt freeze counter; no time-base wakeup
module mct_clock_timebase #(
  parameter logic [17:0] PERIOD0 = `MCT_TB_PERIOD0,
  parameter logic [17:0] PERIOD1 = `MCT_TB_PERIOD1,
  parameter logic [17:0] PERIOD2 = `MCT_TB_PERIOD2,
  parameter logic [17:0] PERIOD3 = `MCT_TB_PERIOD3
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_irq_mask,
  input wire logic halt_req,
  input wire logic wfi_req,
  input wire logic ext_wakeup,
  input wire logic auto_wakeup_halt,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic clk_out_pin_o,
  output logic clk_out_pin_oe,
  output logic half_osc_clock_en,
  output logic cpu_clk_en,
  output logic timebase_irq,
  output logic wakeup,
  output logic [1:0] power_state,
  output logic irq
);
  // ============================================================
  // Reset synchroniser and half-oscillator enable
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic osc_en_ff;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      osc_en_ff <= 1'b0;
    end else begin
      osc_en_ff <= ~osc_en_ff;
    end
  end
  assign half_osc_clock_en = osc_en_ff;

  // ============================================================
  // Power mode
  mct_pkg::mct_power_type pwr_ff;
  mct_pkg::mct_csr_type csr_ff;
  logic tb_event;
  logic regs_frozen;
  logic cnt_run;

  function automatic logic [17:0] period_of(input logic [1:0] sel);
    case (sel)
      2'b00: period_of = PERIOD0;
      2'b01: period_of = PERIOD1;
      2'b10: period_of = PERIOD2;
      2'b11: period_of = PERIOD3;
      default: period_of = PERIOD0;
    endcase
  endfunction : period_of

  assign wakeup = ((pwr_ff == mct_pkg::MCT_WAIT || pwr_ff == mct_pkg::MCT_ACTIVE_HALT)
                   && timebase_irq) || (pwr_ff != mct_pkg::MCT_RUN && ext_wakeup);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ff <= mct_pkg::MCT_RUN;
    end else begin
      case (pwr_ff)
        mct_pkg::MCT_RUN: begin
          if (halt_req) begin
            pwr_ff <= (csr_ff.timebase_irq_enable && !auto_wakeup_halt) ?
                      mct_pkg::MCT_ACTIVE_HALT : mct_pkg::MCT_HALT;
          end else if (wfi_req) begin
            pwr_ff <= mct_pkg::MCT_WAIT;
          end
        end
        mct_pkg::MCT_WAIT, mct_pkg::MCT_ACTIVE_HALT, mct_pkg::MCT_HALT: begin
          if (wakeup) begin
            pwr_ff <= mct_pkg::MCT_RUN;
          end
        end
        default: pwr_ff <= mct_pkg::MCT_RUN;
      endcase
    end
  end
  assign power_state = pwr_ff;

  assign regs_frozen = (pwr_ff == mct_pkg::MCT_ACTIVE_HALT) || (pwr_ff == mct_pkg::MCT_HALT);
  assign cnt_run = osc_en_ff && (pwr_ff != mct_pkg::MCT_HALT);

  // ============================================================
  // Time base counter
  logic [17:0] tb_cnt_ff;
  logic [1:0] tb_sel_ff;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tb_cnt_ff <= 18'h00000;
      tb_sel_ff <= 2'b00;
    end else if (cnt_run) begin
      if (tb_cnt_ff >= period_of(tb_sel_ff) - 18'h00001) begin
        tb_cnt_ff <= 18'h00000;
        tb_sel_ff <= csr_ff.timebase_period_select;
      end else begin
        tb_cnt_ff <= tb_cnt_ff + 18'h00001;
      end
    end
  end
  assign tb_event = cnt_run && (tb_cnt_ff >= period_of(tb_sel_ff) - 18'h00001);

  // ============================================================
  // APB slave
  logic wr_acc;
  logic rd_acc;
  logic rd_csr;
  logic rd_irq_st;
  logic [7:0] irq_st_ff;
  logic [7:0] irq_mask_ff;
  logic [7:0] csr_bits;

  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign rd_csr = rd_acc && (paddr == `MCT_CTRL_STATUS_OFS);
  assign rd_irq_st = rd_acc && (paddr == `MCT_IRQ_STATUS_OFS);
  assign pslverr = psel && penable && !(paddr == `MCT_CTRL_STATUS_OFS ||
                   paddr == `MCT_IRQ_STATUS_OFS || paddr == `MCT_IRQ_MASK_OFS ||
                   paddr == `MCT_POWER_CTRL_OFS);
  assign csr_bits = csr_ff;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      csr_ff <= `MCT_CTRL_STATUS_RST;
    end else begin
      if (wr_acc && paddr == `MCT_CTRL_STATUS_OFS && !regs_frozen) begin
        csr_ff.clock_out_select <= pwdata[`MCT_BIT_CLKOUT];
        csr_ff.cpu_div_select <= pwdata[`MCT_BIT_CPUDIV_HI:`MCT_BIT_CPUDIV_LO];
        csr_ff.slow_mode_select <= pwdata[`MCT_BIT_SLOW];
        csr_ff.timebase_period_select <= pwdata[`MCT_BIT_TB_HI:`MCT_BIT_TB_LO];
        csr_ff.timebase_irq_enable <= pwdata[`MCT_BIT_IRQEN];
      end
      if (tb_event) begin
        csr_ff.timebase_overflow_flag <= 1'b1;
      end else if (rd_csr && prdata[`MCT_BIT_OVF]) begin
        // Clear only a flag the read returned, so a set at setup is kept
        csr_ff.timebase_overflow_flag <= 1'b0;
      end
    end
  end

  // Sticky status: bit0 overflow event, bit1 wakeup event; a read clears what it returned
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_ff <= 8'h00;
    end else begin
      irq_st_ff <= (rd_irq_st ? (irq_st_ff & ~prdata[7:0]) : irq_st_ff) |
                   {6'h00, wakeup, tb_event};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_ff <= 8'h00;
    end else if (wr_acc && paddr == `MCT_IRQ_MASK_OFS) begin
      irq_mask_ff <= pwdata[7:0];
    end
  end
  assign irq = |(irq_st_ff & irq_mask_ff);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `MCT_CTRL_STATUS_OFS: prdata <= {24'h000000, csr_bits};
        `MCT_IRQ_STATUS_OFS: prdata <= {24'h000000, irq_st_ff};
        `MCT_IRQ_MASK_OFS: prdata <= {24'h000000, irq_mask_ff};
        `MCT_POWER_CTRL_OFS: prdata <= {30'h00000000, pwr_ff};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ============================================================
  // Interrupt, clock output and CPU clock
  // enable gate
  assign timebase_irq = csr_ff.timebase_overflow_flag && csr_ff.timebase_irq_enable &&
                        !cpu_irq_mask;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clk_out_pin_o <= 1'b0;
      clk_out_pin_oe <= 1'b0;
    end else begin
      clk_out_pin_o <= csr_ff.clock_out_select ? osc_en_ff : gpio_out;
      clk_out_pin_oe <= csr_ff.clock_out_select ? 1'b1 : gpio_oe;
    end
  end

  mct_cpu_div u_cpu_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .osc_en(osc_en_ff),
    .slow_mode(csr_ff.slow_mode_select),
    .div_sel(csr_ff.cpu_div_select),
    .cpu_en(cpu_clk_en)
  );

  // ============================================================
  // Checks
  chk_irq_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    timebase_irq |-> (csr_ff.timebase_irq_enable && !cpu_irq_mask))
    else $error("irq without enable");
  chk_irq_raise: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (csr_ff.timebase_overflow_flag && csr_ff.timebase_irq_enable && !cpu_irq_mask)
    |-> timebase_irq)
    else $error("irq not raised");
  chk_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tb_event |=> csr_ff.timebase_overflow_flag)
    else $error("overflow flag not set");
  chk_flag_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rd_csr && prdata[`MCT_BIT_OVF] && !tb_event) |=> !csr_ff.timebase_overflow_flag)
    else $error("flag not cleared by read");
  chk_flag_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rd_csr && !prdata[`MCT_BIT_OVF] && csr_ff.timebase_overflow_flag)
    |=> csr_ff.timebase_overflow_flag)
    else $error("unread flag lost");
  chk_halt_active: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pwr_ff == mct_pkg::MCT_RUN && halt_req && csr_ff.timebase_irq_enable && !auto_wakeup_halt)
    |=> pwr_ff == mct_pkg::MCT_ACTIVE_HALT)
    else $error("active halt not entered");
  chk_halt_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pwr_ff == mct_pkg::MCT_HALT && !ext_wakeup) |=> $stable(tb_cnt_ff))
    else $error("counter moved in halt");
  chk_ahalt_regs: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pwr_ff == mct_pkg::MCT_ACTIVE_HALT) |=> $stable(csr_ff.timebase_period_select))
    else $error("register changed in active halt");
  chk_ahalt_wake: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pwr_ff == mct_pkg::MCT_ACTIVE_HALT && timebase_irq) |=> pwr_ff == mct_pkg::MCT_RUN)
    else $error("no wake from active halt");
  chk_wait_wake: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pwr_ff == mct_pkg::MCT_WAIT && timebase_irq) |=> pwr_ff == mct_pkg::MCT_RUN)
    else $error("no wake from wait");
  chk_sel_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !tb_event |=> $stable(tb_sel_ff))
    else $error("period changed mid-period");
  chk_clk_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
    csr_ff.clock_out_select |=> (clk_out_pin_oe && clk_out_pin_o == $past(osc_en_ff)))
    else $error("clock out not driven");
  chk_reset_csr: assert property (@(posedge clk_sys)
    $rose(rst_n) |-> csr_bits == 8'h00)
    else $error("register not cleared");
  chk_period_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tb_event |-> tb_cnt_ff == period_of(tb_sel_ff) - 18'h00001)
    else $error("wrong period length");
  chk_slow_div: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cpu_clk_en && csr_ff.slow_mode_select && csr_ff.cpu_div_select == 2'b00
     && $stable(csr_ff)) |-> ##1 !cpu_clk_en ##1 !cpu_clk_en ##1 !cpu_clk_en)
    else $error("slow divide by 2 wrong");

  cov_tb_event: cover property (@(posedge clk_sys) disable iff (!rst_n) tb_event);
  cov_ahalt_wake: cover property (@(posedge clk_sys) disable iff (!rst_n)
    pwr_ff == mct_pkg::MCT_ACTIVE_HALT ##1 pwr_ff == mct_pkg::MCT_RUN);
  cov_wait_wake: cover property (@(posedge clk_sys) disable iff (!rst_n)
    pwr_ff == mct_pkg::MCT_WAIT ##1 pwr_ff == mct_pkg::MCT_RUN);
endmodule : mct_clock_timebase
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the clock/time base block
`timescale 1ns/1ps
`default_nettype none
`include "mct_map.svh"
module tb_top;
  localparam logic [17:0] P [4] = '{18'h10, 18'h20, 18'h50, 18'hc8};
  localparam logic [11:0] CTRL = `MCT_CTRL_STATUS_OFS;
  localparam logic [11:0] IST = `MCT_IRQ_STATUS_OFS;
  localparam logic [11:0] IMSK = `MCT_IRQ_MASK_OFS;
  localparam logic [11:0] PWR = `MCT_POWER_CTRL_OFS;
  localparam logic [11:0] RA [4] = '{CTRL, IST, IMSK, PWR};
  localparam logic [1:0] SEL [4] = '{2'h2, 2'h0, 2'h1, 2'h3};
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, o1, tbi_q = 1'b0;
  logic cpu_irq_mask = 1'b0, halt_req = 1'b0, wfi_req = 1'b0, ext_wakeup = 1'b0;
  logic auto_wakeup_halt = 1'b0, gpio_out = 1'b1, gpio_oe = 1'b0;
  logic clk_out_pin_o, clk_out_pin_oe, half_osc_clock_en, cpu_clk_en, timebase_irq, wakeup, irq;
  logic [1:0] power_state;
  int n_mismatch = 0, checks_done = 0, gap = 0, cnt = 0, n_rise = 0, npuls = 0, cur, n0;

  always #5 clk_sys = ~clk_sys;

  mct_clock_timebase #(.PERIOD0(P[0]), .PERIOD1(P[1]), .PERIOD2(P[2]), .PERIOD3(P[3])) dut_u (
    .clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cpu_irq_mask, .halt_req, .wfi_req, .ext_wakeup, .auto_wakeup_halt, .gpio_out, .gpio_oe,
    .clk_out_pin_o, .clk_out_pin_oe, .half_osc_clock_en, .cpu_clk_en, .timebase_irq, .wakeup,
    .power_state, .irq);

  // ==========================================
  // Interrupt spacing and CPU enable counting
  always @(posedge clk_sys) begin
    cnt <= cnt + 1;
    tbi_q <= timebase_irq;
    if (timebase_irq && !tbi_q) begin
      gap <= cnt + 1;
      cnt <= 0;
      n_rise <= n_rise + 1;
    end
    if (cpu_clk_en) begin
      npuls <= npuls + 1;
    end
  end

  // ==========================================
  // Tasks
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : step

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int t = 0;
    step(1);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    step(1);
    penable <= 1'b1;
    do begin
      step(1);
      t++;
    end while (pready !== 1'b1 && t < 100);
    if (t >= 100) check("apb wait", 32'h0, 32'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_rise;
    int t = 0;
    int n0 = n_rise;
    while (n_rise == n0 && t < 2000) begin
      step(1);
      t++;
    end
    if (t >= 2000) check("rise wait", 32'h0, 32'h1);
  endtask : wait_rise

  // Read twice just after a period end: flag seen, then gone
  task automatic clr;
    apb(1'b0, CTRL, 32'h0);
    check("flag set", rdat & 32'h1, 32'h1);
    apb(1'b0, CTRL, 32'h0);
    check("flag cleared", rdat & 32'h1, 32'h0);
  endtask : clr

  task automatic req(input int k);
    halt_req <= (k == 0);
    wfi_req <= (k == 1);
    ext_wakeup <= (k == 2);
    step(1);
    {halt_req, wfi_req, ext_wakeup} <= 3'h0;
    step(3);
  endtask : req

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  initial begin
    step(20000);
    n_mismatch++;
    complete_run();
  end

  // ==========================================
  // Main sequence
  initial begin
    step(12);
    reset_n <= 1'b1;
    step(3);
    foreach (RA[i]) begin
      apb(1'b0, RA[i], 32'h0);
      check("reset value", rdat, 32'h0);
    end
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped error", {31'h0, rerr}, 32'h1);
    check("unmapped data", rdat, 32'h0);
    apb(1'b1, CTRL, 32'hf2);
    apb(1'b0, CTRL, 32'h0);
    check("ctrl readback", rdat & 32'hfe, 32'hf2);
    apb(1'b1, CTRL, 32'h80);
    step(3);
    check("pin driven", {31'h0, clk_out_pin_oe}, 32'h1);
    o1 = clk_out_pin_o;
    step(1);
    check("pin toggles", {31'h0, clk_out_pin_o}, {31'h0, ~o1});
    o1 = half_osc_clock_en;
    step(1);
    check("osc enable toggles", {31'h0, half_osc_clock_en}, {31'h0, ~o1});
    apb(1'b1, CTRL, 32'h0);
    step(3);
    check("pin gpio oe", {31'h0, clk_out_pin_oe}, 32'h0);
    check("pin gpio out", {31'h0, clk_out_pin_o}, 32'h1);
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, CTRL, (k < 4) ? (32'h10 | (k << 5)) : 32'h60);
      step(40);
      n0 = npuls;
      step(64);
      check("cpu enables", npuls - n0, (k < 4) ? (64 >> (k + 2)) : 32);
    end
    apb(1'b1, CTRL, 32'h0);
    apb(1'b0, CTRL, 32'h0);
    step(80);
    check("irq disabled", {31'h0, timebase_irq}, 32'h0);
    cpu_irq_mask <= 1'b1;
    apb(1'b1, CTRL, 32'h2);
    step(80);
    check("cpu mask", {31'h0, timebase_irq}, 32'h0);
    cpu_irq_mask <= 1'b0;
    step(2);
    check("irq enabled", {31'h0, timebase_irq}, 32'h1);
    clr();
    wait_rise();
    clr();
    cur = 0;
    foreach (SEL[i]) begin
      apb(1'b1, CTRL, {28'h0, SEL[i], 2'b10});
      wait_rise();
      check("period held", gap, 2 * P[cur]);
      clr();
      wait_rise();
      check("period new", gap, 2 * P[SEL[i]]);
      clr();
      cur = SEL[i];
    end
    apb(1'b0, IST, 32'h0);
    wait_rise();
    check("irq masked", {31'h0, irq}, 32'h0);
    clr();
    apb(1'b1, IMSK, 32'h1);
    step(2);
    check("irq raised", {31'h0, irq}, 32'h1);
    apb(1'b0, IMSK, 32'h0);
    check("mask readback", rdat, 32'h1);
    apb(1'b0, IST, 32'h0);
    check("status bit", rdat & 32'h1, 32'h1);
    step(2);
    check("irq cleared", {31'h0, irq}, 32'h0);
    req(0);
    check("active halt", {30'h0, power_state}, 32'h2);
    apb(1'b1, CTRL, 32'h8e);
    apb(1'b0, CTRL, 32'h0);
    check("regs frozen", rdat, 32'h0e);
    apb(1'b0, PWR, 32'h0);
    check("power reg", rdat, 32'h2);
    wait_rise();
    step(3);
    check("halt counting", gap, 2 * P[3]);
    check("halt woken", {30'h0, power_state}, 32'h0);
    clr();
    req(1);
    check("wait entered", {30'h0, power_state}, 32'h1);
    wait_rise();
    step(3);
    check("wait counting", gap, 2 * P[3]);
    check("wait woken", {30'h0, power_state}, 32'h0);
    clr();
    for (int k = 0; k < 2; k++) begin
      auto_wakeup_halt <= k[0];
      apb(1'b1, CTRL, k ? 32'h0e : 32'h0c);
      apb(1'b0, CTRL, 32'h0);
      // Pending enabled overflow must not wake full halt
      if (k == 1) wait_rise();
      req(0);
      check("full halt", {30'h0, power_state}, 32'h3);
      step(900);
      check("stays halted", {30'h0, power_state}, 32'h3);
      check("no wakeup", {31'h0, wakeup}, 32'h0);
      req(2);
      check("other wake", {30'h0, power_state}, 32'h0);
    end
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
